/* uart_rx_pkg.sv */
// Behaviour
// RL1: receive_complete_flag is one while unread data sits in the buffer, zero when empty.
// RL2: clearing receive_enable_bit flushes the buffer, so receive_complete_flag drops.
// RL3: interrupt requested while irq enable, receive_complete_flag and global enable are set.
// RL4: an interrupt reader must read data_buffer_register in its handler.
// RL5: error flags travel with their frame; reading the data advances the buffer.
// RL6: software writes to the error flag bits of ctrl_status_a are ignored.
// RL7: no interrupt comes from frame, overrun or parity error flags.
// RL8: frame_error_flag is zero if first stop bit read one, else one.
// RL9: only the first stop bit is checked, whatever stop_bit_select says.
// RL10: overrun set on start bit while buffer holds two and shifter holds one.
// RL11: overrun cleared when a frame moves from shifter into the buffer.
// RL12: parity_error_flag reads zero while parity checking is disabled.
// RL13: parity_enable_bit turns checking on, parity_odd_select picks odd or even.
// RL14: parity of data bits compared to parity bit, result stored with frame.
// RL15: parity error only if checking was on for that frame; valid until read.
// RL16: clearing receive_enable_bit stops reception at once and releases the input pin.
// RL17: software flushes by reading data until receive_complete_flag reads zero.
// RL18: input sampled at sixteen times the baud rate, eight with double_speed_bit.
// RL19: start detection begins on a high to low edge; first low is sample 1.
// RL20: start validated with samples 8, 9, 10, or 4, 5, 6 in double speed.
// RL21: majority high among the three samples rejects the start as noise.
// RL22: sampling phase resynchronises on each valid start, then data recovery begins.
// RL23: each data, parity and stop bit is a majority vote of three centre samples.
// RL24: after the first stop bit the frame moves from shifter to buffer.
// RL25: while disabled, start detector and sample counter are held idle.
package uart_rx_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [7:0] DATA_OFS = 8'h00;
   localparam logic [7:0] CSA_OFS = 8'h04;
   localparam logic [7:0] CSB_OFS = 8'h08;
   localparam logic [7:0] CSC_OFS = 8'h0c;
   localparam logic [7:0] BAUD_OFS = 8'h10;

   // field positions
   localparam int CSA_RXC = 7;
   localparam int CSA_FE = 4;
   localparam int CSA_DOR = 3;
   localparam int CSA_PE = 2;
   localparam int CSA_U2X = 1;
   localparam int CSB_RXCIE = 7;
   localparam int CSB_RXEN = 4;
   localparam int CSB_RXB8 = 1;
   localparam int CSC_PEN = 5;
   localparam int CSC_PODD = 4;
   localparam int CSC_STOP2 = 3;

   // reset values
   localparam logic [2:0] SIZE_RST = 3'h3;
   localparam logic [11:0] BAUD_RST = 12'h000;

   // buffer entry layout
   localparam int ENT_W = 12;
   localparam int ENT_PE = 9;
   localparam int ENT_DOR = 10;
   localparam int ENT_FE = 11;

   // sampling
   localparam logic [4:0] SPB_NORMAL = 5'h10;
   localparam logic [4:0] SPB_DOUBLE = 5'h08;
   localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
   localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
   localparam logic [4:0] VOTE_LAST_NORMAL = 5'h0a;
   localparam logic [4:0] VOTE_LAST_DOUBLE = 5'h06;

   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} rx_state_t;

endpackage

/* uart_rx.sv */
`timescale 1ns/100ps
module uart_rx import uart_rx_pkg::*; #(
   parameter int BUF_DEPTH = 2,
   parameter int BAUD_W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic rx_i,
   input wire logic gie_i,
   output logic rx_irq_o,
   output logic rx_override_o
);

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CW = $clog2(BUF_DEPTH + 1);

   if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0 || BAUD_W < 9 || BAUD_W > 16) begin : g_chk
      $error("uart_rx: BUF_DEPTH must be a power of two >= 2, BAUD_W 9..16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic ack_q;
   logic [31:0] dat_q;
   logic irq_q;
   logic ovr_q;
   logic rxcie_q;
   logic en_q;
   logic u2x_q;
   logic pen_q;
   logic podd_q;
   logic stop2_q;
   logic [2:0] size_q;
   logic [BAUD_W-1:0] baud_q;
   logic [BAUD_W-1:0] div_q;
   rx_state_t state_q;
   logic [4:0] smp_q;
   logic [3:0] idx_q;
   logic last_q;
   logic [1:0] v_q;
   logic [8:0] shift_q;
   logic par_q;
   logic pen_frame_q;
   logic podd_frame_q;
   logic pend_v_q;
   logic [ENT_W-1:0] pend_q;
   logic dor_q;
   logic [ENT_W-1:0] mem_q [BUF_DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [CW-1:0] cnt_q;

   logic req_w;
   logic wr_w;
   logic rd_w;
   logic pop_w;
   logic tick_w;
   logic [4:0] spb_w;
   logic [4:0] vfirst_w;
   logic [4:0] vlast_w;
   logic decide_w;
   logic bit_end_w;
   logic bit_w;
   logic start_ok_w;
   logic done_w;
   logic full_w;
   logic xfer_w;
   logic dor_set_w;
   logic rxc_w;
   logic [ENT_W-1:0] head_w;
   logic [3:0] nbits_w;
   logic [7:0] csa_w;
   logic [7:0] csb_w;
   logic [7:0] csc_w;

   function automatic logic [3:0] size_bits(input logic [2:0] code);
      logic [3:0] n;
      unique case (code)
         3'h0: n = 4'h5;
         3'h1: n = 4'h6;
         3'h2: n = 4'h7;
         3'h7: n = 4'h9;
         default: n = 4'h8;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave
   assign req_w = cyc_i & stb_i & ~ack_q;
   assign wr_w = req_w & we_i;
   assign rd_w = req_w & ~we_i;
   assign pop_w = rd_w & (adr_i == DATA_OFS) & rxc_w; // see RL5

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_w;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (rd_w) begin
         unique case (adr_i)
            DATA_OFS: dat_q <= {24'h00_0000, rxc_w ? head_w[7:0] : 8'h00};
            CSA_OFS: dat_q <= {24'h00_0000, csa_w};
            CSB_OFS: dat_q <= {24'h00_0000, csb_w};
            CSC_OFS: dat_q <= {24'h00_0000, csc_w};
            BAUD_OFS: dat_q <= 32'(baud_q);
            default: dat_q <= 32'h0000_0000;
         endcase
      end
   end

   assign dat_o = dat_q;
   assign ack_o = ack_q;

   // error flags only show for a frame that is really there
   always_comb begin
      csa_w = 8'h00;
      csa_w[CSA_RXC] = rxc_w; // see RL1
      csa_w[CSA_FE] = rxc_w & head_w[ENT_FE]; // see RL8
      csa_w[CSA_DOR] = rxc_w & head_w[ENT_DOR];
      csa_w[CSA_PE] = rxc_w & pen_q & head_w[ENT_PE]; // see RL12
      csa_w[CSA_U2X] = u2x_q;
      csb_w = 8'h00;
      csb_w[CSB_RXCIE] = rxcie_q;
      csb_w[CSB_RXEN] = en_q;
      csb_w[CSB_RXB8] = rxc_w & head_w[8];
      csc_w = {2'b00, pen_q, podd_q, stop2_q, size_q};
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         u2x_q <= 1'b0;
         rxcie_q <= 1'b0;
         en_q <= 1'b0;
         pen_q <= 1'b0;
         podd_q <= 1'b0;
         stop2_q <= 1'b0;
         size_q <= SIZE_RST;
      end else if (wr_w && sel_i[0]) begin
         unique case (adr_i)
            CSA_OFS: u2x_q <= dat_i[CSA_U2X]; // see RL6
            CSB_OFS: begin
               rxcie_q <= dat_i[CSB_RXCIE];
               en_q <= dat_i[CSB_RXEN];
            end
            CSC_OFS: begin
               pen_q <= dat_i[CSC_PEN]; // see RL13
               podd_q <= dat_i[CSC_PODD];
               stop2_q <= dat_i[CSC_STOP2];
               size_q <= dat_i[2:0];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_q <= BAUD_W'(BAUD_RST);
      end else if (wr_w && adr_i == BAUD_OFS) begin
         if (sel_i[0]) begin
            baud_q[7:0] <= dat_i[7:0];
         end
         if (sel_i[1]) begin
            baud_q[BAUD_W-1:8] <= dat_i[BAUD_W-1:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample tick
   assign tick_w = en_q & (div_q == baud_q);

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q || tick_w) begin
         div_q <= '0;
      end else begin
         div_q <= BAUD_W'(div_q + 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock and data recovery
   assign spb_w = u2x_q ? SPB_DOUBLE : SPB_NORMAL; // see RL18
   assign vfirst_w = u2x_q ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL; // see RL20
   assign vlast_w = u2x_q ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL;
   assign decide_w = (smp_q == vlast_w);
   assign bit_end_w = (smp_q == spb_w);
   assign bit_w = (v_q[1] & v_q[0]) | (v_q[1] & rx_i) | (v_q[0] & rx_i); // see RL23
   assign nbits_w = size_bits(size_q);
   assign start_ok_w = tick_w & (state_q == ST_START) & decide_w & ~bit_w;
   assign done_w = tick_w & (state_q == ST_STOP) & decide_w;

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q) begin
         state_q <= ST_IDLE; // see RL25
         smp_q <= 5'h01;
         idx_q <= 4'h0;
         last_q <= 1'b1;
         v_q <= 2'b00;
      end else if (tick_w) begin
         if (state_q == ST_IDLE) begin
            last_q <= rx_i;
            if (last_q && !rx_i) begin
               state_q <= ST_START; // see RL19
               // first low sample is already taken, next one is sample 2
               smp_q <= 5'h02;
            end
         end else begin
            smp_q <= bit_end_w ? 5'h01 : 5'(smp_q + 5'h01);
            if (smp_q == vfirst_w || smp_q == 5'(vfirst_w + 5'h01)) begin
               v_q <= {v_q[0], rx_i};
            end
            unique case (state_q)
               ST_START: begin
                  if (decide_w && bit_w) begin
                     state_q <= ST_IDLE; // see RL21
                     last_q <= 1'b1;
                  end else if (bit_end_w) begin
                     state_q <= ST_DATA; // see RL22
                     idx_q <= 4'h0;
                  end
               end
               ST_DATA: begin
                  if (bit_end_w) begin
                     if (idx_q == 4'(nbits_w - 4'h1)) begin
                        state_q <= pen_frame_q ? ST_PARITY : ST_STOP;
                     end else begin
                        idx_q <= 4'(idx_q + 4'h1);
                     end
                  end
               end
               ST_PARITY: begin
                  if (bit_end_w) begin
                     state_q <= ST_STOP;
                  end
               end
               ST_STOP: begin
                  if (decide_w) begin
                     state_q <= ST_IDLE; // see RL9
                     last_q <= bit_w;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_q <= 9'h000;
         par_q <= 1'b0;
         pen_frame_q <= 1'b0;
         podd_frame_q <= 1'b0;
      end else if (tick_w) begin
         if (state_q == ST_IDLE && last_q && !rx_i) begin
            shift_q <= 9'h000;
            pen_frame_q <= pen_q; // see RL15
            podd_frame_q <= podd_q;
         end else if (decide_w && state_q == ST_DATA) begin
            shift_q[idx_q] <= bit_w;
         end else if (decide_w && state_q == ST_PARITY) begin
            par_q <= bit_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift register hold, overrun and receive buffer
   assign rxc_w = (cnt_q != '0);
   assign full_w = (cnt_q == CW'(BUF_DEPTH));
   assign xfer_w = pend_v_q & (~full_w | pop_w);
   assign dor_set_w = start_ok_w & full_w & pend_v_q; // see RL10
   assign head_w = mem_q[rp_q];

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q) begin
         pend_v_q <= 1'b0;
         pend_q <= '0;
      end else if (done_w && (!pend_v_q || xfer_w)) begin
         pend_v_q <= 1'b1; // see RL24
         pend_q[8:0] <= shift_q;
         pend_q[ENT_FE] <= ~bit_w; // see RL8
         pend_q[ENT_DOR] <= 1'b0;
         pend_q[ENT_PE] <= pen_frame_q & (^shift_q ^ par_q ^ podd_frame_q); // see RL14
      end else if (xfer_w) begin
         pend_v_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q) begin
         dor_q <= 1'b0;
      end else if (dor_set_w) begin
         dor_q <= 1'b1;
      end else if (xfer_w) begin
         dor_q <= 1'b0; // see RL11
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0; // see RL2
      end else begin
         if (xfer_w) begin
            wp_q <= PW'(wp_q + 1'b1);
         end
         if (pop_w) begin
            rp_q <= PW'(rp_q + 1'b1); // see RL5
         end
         cnt_q <= CW'(cnt_q + CW'(xfer_w) - CW'(pop_w));
      end
   end

   always_ff @(posedge clk_i) begin
      if (xfer_w) begin
         mem_q[wp_q] <= {pend_q[ENT_FE], dor_q | dor_set_w, pend_q[ENT_PE:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request and pin override
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
         ovr_q <= 1'b0;
      end else begin
         irq_q <= rxcie_q & rxc_w & gie_i; // see RL3, RL7
         ovr_q <= en_q; // see RL16
      end
   end

   assign rx_irq_o = irq_q;
   assign rx_override_o = ovr_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_last_read_clears: assert property ( // see RL1
      pop_w && cnt_q == CW'(1) && !xfer_w |=> !csa_w[CSA_RXC])
      else $error("flag stayed set after last entry read");

   a_flush_on_disable: assert property ( // see RL2
      $fell(en_q) |=> cnt_q == '0 && !pend_v_q && !csa_w[CSA_RXC])
      else $error("buffer not flushed on disable");

   a_irq_follows_flag: assert property ( // see RL3
      rxcie_q && rxc_w && gie_i |=> rx_irq_o)
      else $error("interrupt not requested");

   a_irq_needs_flag: assert property ( // see RL7
      rx_irq_o |-> $past(rxc_w) && $past(rxcie_q) && $past(gie_i))
      else $error("interrupt without receive complete");

   a_read_advances: assert property ( // see RL5
      pop_w |=> rp_q != $past(rp_q))
      else $error("read position did not advance");

   a_flag_write_ignored: assert property ( // see RL6
      wr_w && adr_i == CSA_OFS && !xfer_w && !pop_w |=> $stable(csa_w[CSA_FE:CSA_PE]))
      else $error("error flags changed by write");

   a_stop_sets_fe: assert property ( // see RL8
      done_w && !pend_v_q |=> pend_v_q && pend_q[ENT_FE] == !$past(bit_w))
      else $error("frame error not taken from stop bit");

   a_overrun_set: assert property ( // see RL10
      dor_set_w |=> dor_q || mem_q[$past(wp_q)][ENT_DOR])
      else $error("overrun not recorded");

   a_overrun_clear: assert property ( // see RL11
      xfer_w && !dor_set_w |=> !dor_q)
      else $error("overrun not cleared on transfer");

   a_parity_off_zero: assert property ( // see RL12
      !pen_q |-> !csa_w[CSA_PE])
      else $error("parity error shown while disabled");

   a_noise_rejected: assert property ( // see RL21
      tick_w && state_q == ST_START && decide_w && bit_w |=> state_q == ST_IDLE)
      else $error("noise start not rejected");

   a_start_vote_point: assert property ( // see RL20
      start_ok_w |-> smp_q == (u2x_q ? 5'h06 : 5'h0a))
      else $error("start validated at wrong sample");

   a_disabled_idle: assert property ( // see RL25
      !en_q |=> state_q == ST_IDLE && smp_q == 5'h01)
      else $error("receiver active while disabled");

   c_frame_stored: cover property (xfer_w && !full_w);
   c_start_rejected: cover property (tick_w && state_q == ST_START && decide_w && bit_w);
   c_overrun: cover property (dor_set_w);
   c_double_speed_frame: cover property (done_w && u2x_q);

endmodule

/* uart_line_model.sv */
`timescale 1ns/100ps
module uart_line_model (
   input wire logic clk_i,
   output logic line_o
);
   initial line_o = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // one frame, start then data lsb first, optional parity, one stop bit
   task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic stp,
         input int spb);
      logic [10:0] bits;
      int n;
      bits = pe ? {stp, pb, d, 1'b0} : {1'b1, stp, d, 1'b0};
      n = pe ? 11 : 10;
      @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         line_o <= bits[i];
         repeat (spb) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // short low pulse on an idle line
   task automatic noise(input int len);
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (len) @(posedge clk_i);
      line_o <= 1'b1;
   endtask
endmodule

/* uart_receiver_buffer_and_start_detect_bench.sv */
`timescale 1ns/100ps
module uart_receiver_buffer_and_start_detect_bench import uart_rx_pkg::*;
   ;
   logic clk_i;
   logic rst_i;
   logic cyc_i;
   logic stb_i;
   logic we_i;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic ack_o;
   logic rx_i;
   logic gie_i;
   logic rx_irq_o;
   logic rx_override_o;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   uart_rx #(.BUF_DEPTH(2), .BAUD_W(12)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .rx_i(rx_i), .gie_i(gie_i), .rx_irq_o(rx_irq_o),
      .rx_override_o(rx_override_o));
   uart_line_model i_line (.clk_i(clk_i), .line_o(rx_i));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // reporting
   task automatic close_out;
      if (num_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wishbone classic master
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] q);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, {24'h00_0000, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      rd_chk(CSA_OFS, 8'h00);
      rd_chk(CSB_OFS, 8'h00);
      rd_chk(CSC_OFS, 8'h03);
      rd_chk(BAUD_OFS, 8'h00);
      rd_chk(8'h20, 8'h00);
      chk({31'h0, rx_override_o}, 32'h0000_0000);
   endtask

   task automatic t_basic;
      wr(CSC_OFS, 8'h0b);
      wr(CSB_OFS, 8'h90);
      i_line.send(8'ha5, 1'b0, 1'b0, 1'b1, 16);
      repeat (2) @(posedge clk_i);
      chk({31'h0, rx_override_o}, 32'h0000_0001);
      rd_chk(CSA_OFS, 8'h80);
      chk({31'h0, rx_irq_o}, 32'h0000_0001);
      gie_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({31'h0, rx_irq_o}, 32'h0000_0000);
      gie_i <= 1'b1;
      rd_chk(DATA_OFS, 8'ha5);
      repeat (2) @(posedge clk_i);
      chk({31'h0, rx_irq_o}, 32'h0000_0000);
      rd_chk(CSA_OFS, 8'h00);
   endtask

   task automatic t_errors;
      wr(CSB_OFS, 8'h10);
      i_line.send(8'h3c, 1'b0, 1'b0, 1'b0, 16);
      rd_chk(CSA_OFS, 8'h90);
      chk({31'h0, rx_irq_o}, 32'h0000_0000);
      wr(CSA_OFS, 8'h1c);
      rd_chk(CSA_OFS, 8'h90);
      rd_chk(DATA_OFS, 8'h3c);
      rd_chk(CSA_OFS, 8'h00);
   endtask

   task automatic t_parity;
      wr(CSC_OFS, 8'h23);
      i_line.send(8'h07, 1'b1, 1'b0, 1'b1, 16);
      rd_chk(CSA_OFS, 8'h84);
      rd_chk(DATA_OFS, 8'h07);
      wr(CSC_OFS, 8'h33);
      i_line.send(8'h07, 1'b1, 1'b0, 1'b1, 16);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'h07);
      wr(CSC_OFS, 8'h23);
      i_line.send(8'h07, 1'b1, 1'b0, 1'b1, 16);
      wr(CSC_OFS, 8'h03);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'h07);
   endtask

   task automatic t_overrun;
      i_line.send(8'h11, 1'b0, 1'b0, 1'b1, 16);
      i_line.send(8'h22, 1'b0, 1'b0, 1'b1, 16);
      i_line.send(8'h33, 1'b0, 1'b0, 1'b1, 16);
      i_line.send(8'h44, 1'b0, 1'b0, 1'b1, 16);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'h11);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'h22);
      rd_chk(CSA_OFS, 8'h88);
      rd_chk(DATA_OFS, 8'h33);
      rd_chk(CSA_OFS, 8'h00);
      i_line.send(8'h55, 1'b0, 1'b0, 1'b1, 16);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'h55);
   endtask

   task automatic t_noise;
      i_line.noise(8);
      repeat (200) @(posedge clk_i);
      rd_chk(CSA_OFS, 8'h00);
      i_line.send(8'h5a, 1'b0, 1'b0, 1'b1, 16);
      rd_chk(DATA_OFS, 8'h5a);
      i_line.noise(9);
      repeat (200) @(posedge clk_i);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'hff);
   endtask

   task automatic t_size;
      wr(CSC_OFS, 8'h07);
      i_line.send(8'h5a, 1'b1, 1'b1, 1'b1, 16);
      rd_chk(CSB_OFS, 8'h12);
      rd_chk(DATA_OFS, 8'h5a);
      wr(CSC_OFS, 8'h00);
      i_line.send(8'hf3, 1'b0, 1'b0, 1'b1, 16);
      rd_chk(CSA_OFS, 8'h80);
      rd_chk(DATA_OFS, 8'h13);
      wr(CSC_OFS, 8'h03);
   endtask

   task automatic t_baud;
      wr(BAUD_OFS, 8'h01);
      rd_chk(BAUD_OFS, 8'h01);
      i_line.send(8'h96, 1'b0, 1'b0, 1'b1, 32);
      rd_chk(DATA_OFS, 8'h96);
      wr(BAUD_OFS, 8'h00);
   endtask

   task automatic t_double;
      wr(CSA_OFS, 8'h02);
      i_line.send(8'hc3, 1'b0, 1'b0, 1'b1, 8);
      rd_chk(CSA_OFS, 8'h82);
      rd_chk(DATA_OFS, 8'hc3);
      wr(CSA_OFS, 8'h00);
   endtask

   task automatic t_disable;
      i_line.send(8'h66, 1'b0, 1'b0, 1'b1, 16);
      wr(CSB_OFS, 8'h00);
      rd_chk(CSA_OFS, 8'h00);
      chk({31'h0, rx_override_o}, 32'h0000_0000);
      i_line.send(8'h12, 1'b0, 1'b0, 1'b1, 16);
      wr(CSB_OFS, 8'h10);
      rd_chk(CSA_OFS, 8'h00);
      fork
         i_line.send(8'hff, 1'b0, 1'b0, 1'b1, 16);
         begin
            repeat (40) @(posedge clk_i);
            wr(CSB_OFS, 8'h00);
            wr(CSB_OFS, 8'h10);
         end
      join
      repeat (20) @(posedge clk_i);
      rd_chk(CSA_OFS, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'hf;
      dat_i = 32'h0000_0000;
      gie_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_basic();
      t_errors();
      t_parity();
      t_overrun();
      t_noise();
      t_double();
      t_size();
      t_baud();
      t_disable();
      close_out();
   end
endmodule
